// *** hdl/panel_out_pkg.sv ***
`default_nettype none
package panel_out_pkg;
  // Register byte offsets
  localparam logic [7:0]  CTRL_ADDR       = 8'h00;
  localparam logic [7:0]  STATUS_ADDR     = 8'h04;
  // Control fields
  localparam int          CTRL_PWR        = 0;
  localparam int          CTRL_WIDE       = 1;
  localparam int          CTRL_DUAL       = 2;
  localparam int          CTRL_DITH       = 3;
  localparam int          CTRL_RES_LSB    = 4;
  localparam int          CTRL_DEPTH_LSB  = 8;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0802;
  // Status fields
  localparam int          STAT_ON         = 3;
  localparam int          STAT_FRAME_LSB  = 16;
  // Blanking in shift clocks and lines
  localparam logic [10:0] H_FP            = 11'h010;
  localparam logic [10:0] H_SW            = 11'h020;
  localparam logic [10:0] H_BP            = 11'h030;
  localparam logic [10:0] V_FP            = 11'h003;
  localparam logic [10:0] V_SW            = 11'h004;
  localparam logic [10:0] V_BP            = 11'h014;
  // Power sequencing step
  localparam int          CLK_MHZ         = 100;
  localparam int          POWER_STEP_US   = 10000;
  localparam int          POWER_STEP_CYC  = POWER_STEP_US * CLK_MHZ;

  typedef enum {PWR_OFF, UP_VDD, UP_DATA, PWR_ON, DN_DATA, DN_VDD} pwr_state_t;

  function automatic logic [10:0] res_width(input logic [2:0] sel);
    case (sel)
      3'h0:    res_width = 11'd320;
      3'h1:    res_width = 11'd640;
      3'h2:    res_width = 11'd800;
      3'h3:    res_width = 11'd1024;
      3'h4:    res_width = 11'd1280;
      default: res_width = 11'd1600;
    endcase
  endfunction : res_width

  function automatic logic [10:0] res_height(input logic [2:0] sel);
    case (sel)
      3'h0:    res_height = 11'd240;
      3'h1:    res_height = 11'd480;
      3'h2:    res_height = 11'd600;
      3'h3:    res_height = 11'd768;
      3'h4:    res_height = 11'd1024;
      default: res_height = 11'd1200;
    endcase
  endfunction : res_height
endpackage : panel_out_pkg
`default_nettype wire

// *** hdl/panel_output_unit.sv ***
`default_nettype none
module panel_output_unit #(
  parameter int POWER_STEP_CYCLES = panel_out_pkg::POWER_STEP_CYC
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pixel stream from video logic, two pixels, first in low half
  input  wire logic [47:0] pix_in,
  input  wire logic        pix_valid,
  output logic             pix_take,
  // Panel shift clock, sampled
  input  wire logic        shift_clk,
  // Panel pins
  output logic      [47:0] panel_colour_out,
  output logic             hsync,
  output logic             vsync,
  output logic             line_data_valid,
  output logic             panel_vdd_on,
  output logic             backlight_on,
  output logic             display_output_on
);
  logic [31:0] ctrl;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic [15:0] frame_cnt;
  logic [2:0]  sclk_sync;
  logic        shift_edge;
  logic [10:0] hcnt, vcnt;
  logic [10:0] hact, vact, htot, vtot;
  logic        de_now;
  logic [3:0]  depth, drop;
  panel_out_pkg::pwr_state_t pwr;
  logic [31:0] step_cnt;

  // Bus slave: zero wait, read data captured at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
    end else begin
      wr_pend <= hsel && hready && htrans[1] && hwrite;
      wr_addr <= haddr[7:0];
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          panel_out_pkg::CTRL_ADDR:   hrdata <= ctrl;
          panel_out_pkg::STATUS_ADDR: hrdata <= {frame_cnt, 12'h000, display_output_on, 3'(pwr)};
          default:                    hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= panel_out_pkg::CTRL_RESET;
    end else if (wr_pend && wr_addr == panel_out_pkg::CTRL_ADDR) begin
      ctrl <= {20'h00000, hwdata[11:0]};
    end
  end

  // Shift clock edge finder; first stage feeds only the second
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_sync <= 3'h0;
    end else begin
      sclk_sync <= {sclk_sync[1:0], shift_clk};
    end
  end
  assign shift_edge = sclk_sync[1] && !sclk_sync[2];

  // Power sequence: supply, then data, then backlight; reverse on the way down
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr               <= panel_out_pkg::PWR_OFF;
      step_cnt          <= 32'h0000_0000;
      panel_vdd_on      <= 1'b0;
      backlight_on      <= 1'b0;
      display_output_on <= 1'b0;
    end else begin
      step_cnt <= step_cnt + 32'h0000_0001;
      case (pwr)
        panel_out_pkg::PWR_OFF: if (ctrl[panel_out_pkg::CTRL_PWR]) begin
          pwr <= panel_out_pkg::UP_VDD;
          panel_vdd_on <= 1'b1;
          step_cnt <= 32'h0000_0000;
        end
        panel_out_pkg::UP_VDD: if (step_cnt >= 32'(POWER_STEP_CYCLES - 1)) begin
          pwr <= panel_out_pkg::UP_DATA;
          display_output_on <= 1'b1;
          step_cnt <= 32'h0000_0000;
        end
        panel_out_pkg::UP_DATA: if (step_cnt >= 32'(POWER_STEP_CYCLES - 1)) begin
          pwr <= panel_out_pkg::PWR_ON;
          backlight_on <= 1'b1;
        end
        panel_out_pkg::PWR_ON: if (!ctrl[panel_out_pkg::CTRL_PWR]) begin
          pwr <= panel_out_pkg::DN_DATA;
          backlight_on <= 1'b0;
          step_cnt <= 32'h0000_0000;
        end
        panel_out_pkg::DN_DATA: if (step_cnt >= 32'(POWER_STEP_CYCLES - 1)) begin
          pwr <= panel_out_pkg::DN_VDD;
          display_output_on <= 1'b0;
          step_cnt <= 32'h0000_0000;
        end
        panel_out_pkg::DN_VDD: if (step_cnt >= 32'(POWER_STEP_CYCLES - 1)) begin
          pwr <= panel_out_pkg::PWR_OFF;
          panel_vdd_on <= 1'b0;
        end
        default: pwr <= panel_out_pkg::PWR_OFF;
      endcase
    end
  end

  // Timing geometry; dual mode halves the active clocks per line, blanking unchanged
  always_comb begin
    hact   = ctrl[panel_out_pkg::CTRL_DUAL] ?
             (panel_out_pkg::res_width(ctrl[6:4]) >> 1) : panel_out_pkg::res_width(ctrl[6:4]);
    vact   = panel_out_pkg::res_height(ctrl[6:4]);
    htot   = hact + panel_out_pkg::H_FP + panel_out_pkg::H_SW + panel_out_pkg::H_BP;
    vtot   = vact + panel_out_pkg::V_FP + panel_out_pkg::V_SW + panel_out_pkg::V_BP;
    de_now = (hcnt < hact) && (vcnt < vact);
    depth  = ctrl[11:8] < 4'd4 ? 4'd4 : (ctrl[11:8] > 4'd8 ? 4'd8 : ctrl[11:8]);
    if (!ctrl[panel_out_pkg::CTRL_WIDE] && depth > 4'd6) begin
      depth = 4'd6;
    end
    drop   = 4'd8 - depth;
  end

  // Ordered 2x2 dither, then truncation to the panel depth
  function automatic logic [7:0] dith(input logic [7:0] c, input logic [3:0] dr,
                                      input logic [1:0] b, input logic en);
    logic [7:0] add;
    logic [8:0] s;
    add  = (en && dr >= 4'd2) ? (8'(b) << (dr - 4'd2)) : 8'h00;
    s    = {1'b0, c} + {1'b0, add};
    dith = (s[8] ? 8'hff : s[7:0]) & (8'hff << dr);
  endfunction : dith

  function automatic logic [23:0] fmt(input logic [23:0] p, input logic [3:0] dr,
                                      input logic [1:0] b, input logic en, input logic wide);
    logic [7:0] r, g, bl;
    r   = dith(p[23:16], dr, b, en);
    g   = dith(p[15:8], dr, b, en);
    bl  = dith(p[7:0], dr, b, en);
    fmt = wide ? {r, g, bl} : {6'h00, r[7:2], g[7:2], bl[7:2]};
  endfunction : fmt

  // Pixel pipe: panel pins and timing advance together on shift edges only; pix_take pulses for one hclk
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hcnt             <= 11'h000;
      vcnt             <= 11'h000;
      frame_cnt        <= 16'h0000;
      panel_colour_out <= 48'h0000_0000_0000;
      hsync            <= 1'b0;
      vsync            <= 1'b0;
      line_data_valid  <= 1'b0;
      pix_take         <= 1'b0;
    end else begin
      pix_take <= 1'b0;
      if (!display_output_on) begin
        hcnt <= 11'h000;
        vcnt <= 11'h000;
      end else if (shift_edge) begin
        line_data_valid <= de_now;
        hsync <= (hcnt >= hact + panel_out_pkg::H_FP) &&
                 (hcnt < hact + panel_out_pkg::H_FP + panel_out_pkg::H_SW);
        vsync <= (vcnt >= vact + panel_out_pkg::V_FP) &&
                 (vcnt < vact + panel_out_pkg::V_FP + panel_out_pkg::V_SW);
        if (de_now && pix_valid) begin
          pix_take <= 1'b1;
          panel_colour_out <= {
            fmt(pix_in[47:24], drop,
                ctrl[panel_out_pkg::CTRL_DUAL] ? {~vcnt[0], 1'b1} : {~vcnt[0] ^ ~hcnt[0], ~hcnt[0]},
                ctrl[panel_out_pkg::CTRL_DITH], ctrl[panel_out_pkg::CTRL_WIDE]),
            fmt(pix_in[23:0], drop,
                ctrl[panel_out_pkg::CTRL_DUAL] ? {vcnt[0], 1'b0} : {hcnt[0] ^ vcnt[0], hcnt[0]},
                ctrl[panel_out_pkg::CTRL_DITH], ctrl[panel_out_pkg::CTRL_WIDE])};
        end else if (!de_now) begin
          panel_colour_out <= 48'h0000_0000_0000;
        end
        if (hcnt >= htot - 11'h001) begin
          hcnt <= 11'h000;
          if (vcnt >= vtot - 11'h001) begin
            vcnt      <= 11'h000;
            frame_cnt <= frame_cnt + 16'h0001;
          end else begin
            vcnt <= vcnt + 11'h001;
          end
        end else begin
          hcnt <= hcnt + 11'h001;
        end
      end
    end
  end

  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_hold_off;
    !display_output_on && !$past(display_output_on) |-> $stable(panel_colour_out);
  endproperty
  a_hold_off: assert property (p_hold_off) else $error("colour moved while off");

  property p_narrow_zero;
    shift_edge && display_output_on && !ctrl[1] |=> panel_colour_out[23:18] == 6'h00
      && panel_colour_out[47:42] == 6'h00;
  endproperty
  a_narrow_zero: assert property (p_narrow_zero) else $error("upper bits set in narrow mode");

  property p_take_edge;
    pix_take |-> $past(shift_edge) && $past(display_output_on) && line_data_valid;
  endproperty
  a_take_edge: assert property (p_take_edge) else $error("pixel taken off edge");

  property p_align;
    $changed(line_data_valid) || $changed(hsync) || $changed(vsync) |-> $past(shift_edge);
  endproperty
  a_align: assert property (p_align) else $error("timing changed between edges");

  property p_bkl_order;
    $rose(backlight_on) |-> panel_vdd_on && display_output_on;
  endproperty
  a_bkl_order: assert property (p_bkl_order) else $error("backlight before supply");

  property p_vdd_last;
    $fell(panel_vdd_on) |-> !display_output_on && !backlight_on;
  endproperty
  a_vdd_last: assert property (p_vdd_last) else $error("supply dropped early");

  // Only after an advance under a settled config; a mid-line mode change may overshoot once
  property p_hbound;
    display_output_on && $past(shift_edge) && $stable(ctrl) |-> hcnt < htot && vcnt < vtot;
  endproperty
  a_hbound: assert property (p_hbound) else $error("counter beyond frame");

  property p_pass;
    shift_edge && display_output_on && de_now && pix_valid && ctrl[1] && !ctrl[3]
      && ctrl[11:8] == 4'd8 |=> panel_colour_out == $past(pix_in);
  endproperty
  a_pass: assert property (p_pass) else $error("undithered pixel altered");

  property p_dual_line;
    shift_edge && display_output_on && ctrl[2]
      && hcnt == (panel_out_pkg::res_width(ctrl[6:4]) >> 1) |=> !line_data_valid;
  endproperty
  a_dual_line: assert property (p_dual_line) else $error("dual line length wrong");

  property p_dual_full;
    shift_edge && display_output_on && ctrl[2] && vcnt < vact
      && hcnt == (panel_out_pkg::res_width(ctrl[6:4]) >> 1) - 11'h001 |=> line_data_valid;
  endproperty
  a_dual_full: assert property (p_dual_full) else $error("dual line cut short");

  c_power_on:  cover property ($rose(backlight_on));
  c_take:      cover property (pix_take);
  c_dual_take: cover property (pix_take && ctrl[2]);
  c_frame:     cover property ($changed(frame_cnt));
endmodule : panel_output_unit
`default_nettype wire

// *** test/panel_model.sv ***
`default_nettype none
module panel_model (
  // Control
  input  wire logic run,
  // Panel pins
  input  wire logic line_data_valid,
  output logic      shift_clk,
  output int        px_count
);
  timeunit 1ns;
  timeprecision 1ps;
  // Offset so shift edges never meet hclk edges; stands low between runs
  initial begin
    shift_clk = 1'b0;
    px_count = 0;
    #3;
    forever #80 shift_clk = run ? ~shift_clk : 1'b0;
  end
  // Panel latches a pixel on each rising shift edge while line_data_valid is high
  always @(posedge shift_clk) begin
    if (line_data_valid === 1'b1) px_count <= px_count + 1;
  end
endmodule : panel_model
`default_nettype wire

// *** test/panel_output_unit_tb_top.sv ***
`default_nettype none
module panel_output_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STEP = 20;
  localparam int LIMIT = 85000;
  localparam logic [47:0] PIX = 48'h13579b_f0e1d2;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic        pix_valid = 1'b0, run = 1'b0;
  logic        hreadyout, hresp, pix_take, shift_clk, hsync, vsync, line_data_valid;
  logic        panel_vdd_on, backlight_on, display_output_on;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [47:0] pix_in = PIX, panel_colour_out, held;
  int          n_fail = 0, comparisons = 0, cycles = 0, takes = 0;
  int          px_count, t0, p0, n;

  always #5 hclk = ~hclk;

  panel_output_unit #(.POWER_STEP_CYCLES(STEP)) DUT (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pix_in, .pix_valid,
    .pix_take, .shift_clk, .panel_colour_out, .hsync, .vsync, .line_data_valid,
    .panel_vdd_on, .backlight_on, .display_output_on
  );

  panel_model PANEL (.run, .line_data_valid, .shift_clk, .px_count);

  task automatic check(input logic [47:0] seen, input logic [47:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : ahb

  task automatic wait_ldv(input logic v);
    for (n = 0; n < 9000 && line_data_valid !== v; n++) @(negedge hclk);
  endtask : wait_ldv

  // Skips the line in flight, so a config change lands before measuring
  task automatic line_check(input int px, input logic [47:0] mask, input logic [47:0] exp,
                            input logic vary);
    wait_ldv(1'b1);
    wait_ldv(1'b0);
    repeat (40) @(negedge hclk);
    check(panel_colour_out, 48'h0, "blank colour");
    check(hsync, 1'b0, "front porch");
    repeat (480) @(negedge hclk);
    check(hsync, 1'b1, "line sync");
    t0 = takes;
    p0 = px_count;
    wait_ldv(1'b1);
    repeat (40) @(negedge hclk);
    check(panel_colour_out & mask, exp, "active colour");
    check(vsync, 1'b0, "no frame sync in line");
    held = panel_colour_out;
    repeat (16) @(negedge hclk);
    check(held != panel_colour_out, vary, "neighbour pixels");
    wait_ldv(1'b0);
    check(takes - t0, px, "takes per line");
    check(px_count - p0, px, "panel pixels");
    $display("line test done");
  endtask : line_check

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (pix_take === 1'b1) begin
      takes <= takes + 1;
      check(line_data_valid, 1'b1, "take outside line");
    end
    if (cycles == LIMIT) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ahb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h802, "ctrl reset");
    check({hreadyout, hresp}, 2'b10, "bus response");
    ahb(1'b1, 8'h04, 32'hffff_ffff);
    ahb(1'b1, 8'h08, 32'hffff_ffff);
    ahb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0, "unmapped read");
    ahb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0, "status read only");
    for (int r = 0; r < 6; r++) begin
      ahb(1'b1, 8'h00, 32'h802 | (r << 4));
      ahb(1'b0, 8'h00, 32'h0);
      check(rd, 32'h802 | (r << 4), "resolution");
    end
    $display("register test done");
    pix_valid <= 1'b1;
    run <= 1'b1;
    ahb(1'b1, 8'h00, 32'h803);
    repeat (2) @(negedge hclk);
    check({panel_vdd_on, display_output_on, backlight_on}, 3'b100, "vdd first");
    for (n = 0; n < 4 * STEP && display_output_on !== 1'b1; n++) @(negedge hclk);
    check({panel_vdd_on, display_output_on, backlight_on}, 3'b110, "display next");
    for (n = 0; n < 4 * STEP && backlight_on !== 1'b1; n++) @(negedge hclk);
    check({panel_vdd_on, display_output_on, backlight_on}, 3'b111, "backlight");
    check(n >= STEP - 2, 1'b1, "step length");
    ahb(1'b0, 8'h04, 32'h0);
    check(rd[3:0], 4'hb, "status on");
    $display("power up test done");
    line_check(320, 48'hff_ffff, 48'hf0e1d2, 1'b0);
    ahb(1'b1, 8'h00, 32'h801);
    line_check(320, 48'hff_ffff, 48'h03ce34, 1'b0);
    ahb(1'b1, 8'h00, 32'h807);
    line_check(160, 48'hffff_ffff_ffff, PIX, 1'b0);
    ahb(1'b1, 8'h00, 32'h40b);
    // Flat level between two 4-bit steps: dither must make neighbours differ
    pix_in <= 48'h0b0b0b_0b0b0b;
    line_check(320, 48'h0f_0f0f, 48'h0, 1'b1);
    ahb(1'b1, 8'h00, 32'h40a);
    for (n = 0; n < 4 * STEP && display_output_on !== 1'b0; n++) @(negedge hclk);
    check({panel_vdd_on, backlight_on}, 2'b10, "backlight off first");
    held = panel_colour_out;
    t0 = takes;
    repeat (640) @(negedge hclk);
    check(panel_colour_out, held, "colour held");
    check(takes - t0, 0, "no advance");
    check(panel_vdd_on, 1'b0, "vdd off last");
    $display("power down test done");
    tally_and_finish();
  end
endmodule : panel_output_unit_tb_top
`default_nettype wire
